// *** fcm_consts.svh ***
// Timing counts, bus addresses, command bytes and status bit positions for the flash command master.
`ifndef FCM_CONSTS_SVH
`define FCM_CONSTS_SVH

`define FCM_CLK_MHZ          40
`define FCM_T_WP_NS          35
`define FCM_WP_CYC           ((`FCM_T_WP_NS * `FCM_CLK_MHZ + 999) / 1000)
`define FCM_T_ACC_NS         70
`define FCM_ACC_CYC          ((`FCM_T_ACC_NS * `FCM_CLK_MHZ + 999) / 1000)
`define FCM_T_RP_NS          500
`define FCM_RP_CYC           ((`FCM_T_RP_NS * `FCM_CLK_MHZ + 999) / 1000)
`define FCM_T_LOADWIN_US     30
`define FCM_LOADWIN_CYC      (`FCM_T_LOADWIN_US * `FCM_CLK_MHZ)

`define FCM_U1_WORD          18'h0_0555
`define FCM_U2_WORD          18'h0_02AA
`define FCM_U1_BYTE          18'h0_0AAA
`define FCM_U2_BYTE          18'h0_0555
`define FCM_PV_OFS_WORD      18'h0_0002
`define FCM_PV_OFS_BYTE      18'h0_0004

`define FCM_D_UNLOCK1        16'h00AA
`define FCM_D_UNLOCK2        16'h0055
`define FCM_D_PROGRAM        16'h00A0
`define FCM_D_SETUP_ERASE    16'h0080
`define FCM_D_SILICON_ID     16'h0090
`define FCM_D_CHIP_ERASE     16'h0010
`define FCM_D_SECTOR_ERASE   16'h0030
`define FCM_D_PROTECT_UNLOCK 16'h0020
`define FCM_D_SUSPEND        16'h00B0
`define FCM_D_RESET          16'h00F0

`define FCM_BIT_POLL         7
`define FCM_BIT_TOGGLE       6
`define FCM_BIT_LIMIT        5

`endif

// *** fcm_pkg.sv ***
// Types shared by the flash command master modules.
package fcm_pkg;
  typedef enum logic [3:0] {
    OP_READ            = 4'h0,
    OP_RESET           = 4'h1,
    OP_PROGRAM         = 4'h2,
    OP_CHIP_ERASE      = 4'h3,
    OP_SECTOR_ERASE    = 4'h4,
    OP_ADD_SECTOR      = 4'h5,
    OP_SUSPEND         = 4'h6,
    OP_RESUME          = 4'h7,
    OP_READ_ID         = 4'h8,
    OP_PROTECT_VERIFY  = 4'h9,
    OP_PROTECT_UNLOCK  = 4'hA,
    OP_POLL            = 4'hB
  } fcm_op_t;

  typedef enum logic [1:0] {
    S_HWRST = 2'b00,
    S_IDLE  = 2'b01,
    S_ISSUE = 2'b10,
    S_WAIT  = 2'b11
  } fcm_state_t;

  typedef enum logic [1:0] {
    K_WRITE = 2'b00,
    K_READ  = 2'b01,
    K_POLLA = 2'b10,
    K_POLLB = 2'b11
  } fcm_kind_t;

  typedef enum logic [1:0] {
    E_IDLE   = 2'b00,
    E_SETUP  = 2'b01,
    E_STROBE = 2'b10,
    E_HOLD   = 2'b11
  } fcm_eng_t;
endpackage : fcm_pkg

// *** fcm_cyc_if.sv ***
// Handshake between the command sequencer and the pin cycle engine.
`timescale 1ns/1ps
`default_nettype none
interface fcm_cyc_if;
  logic        start;
  logic        wr;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport ctl (output start, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input start, input wr, input addr, input wdata, output done, output rdata);
endinterface : fcm_cyc_if
`default_nettype wire

// *** fcm_bus_cycle.sv ***
// Pin cycle engine: one timed write or read cycle on the flash bus.
`timescale 1ns/1ps
`default_nettype none
`include "fcm_consts.svh"
module fcm_bus_cycle (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        byte_mode,
  fcm_cyc_if.eng           cyc,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [16:0]      addr_pins,
  output logic [15:0]      dq_out,
  output logic [15:0]      dq_oe_n,
  input  wire logic [15:0] dq_in
);
  fcm_pkg::fcm_eng_t st_ff;
  logic [2:0]        cnt_ff;
  logic              wr_ff;
  logic              ce_n_ff;
  logic              oe_n_ff;
  logic              we_n_ff;
  logic [16:0]       addr_ff;
  logic [15:0]       dout_ff;
  logic [15:0]       doe_n_ff;
  logic [15:0]       rdata_ff;

  // In byte mode the top data pin carries the lowest address bit, so it is driven on reads too.
  wire [16:0] pin_addr = byte_mode ? cyc.addr[17:1] : cyc.addr[16:0];
  wire [15:0] pin_dout = byte_mode ? {cyc.addr[0], cyc.wdata[14:0]} : cyc.wdata;
  wire [15:0] pin_doe  = cyc.wr ? 16'h0000 : (byte_mode ? 16'h7FFF : 16'hFFFF);
  wire [2:0]  strobe_n = cyc.wr ? 3'(`FCM_WP_CYC - 1) : 3'(`FCM_ACC_CYC - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff    <= fcm_pkg::E_IDLE;
      cnt_ff   <= 3'h0;
      wr_ff    <= 1'b0;
      ce_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      addr_ff  <= 17'h0_0000;
      dout_ff  <= 16'h0000;
      doe_n_ff <= 16'hFFFF;
      rdata_ff <= 16'h0000;
    end else begin
      case (st_ff)
        fcm_pkg::E_IDLE: begin
          if (cyc.start) begin
            st_ff    <= fcm_pkg::E_SETUP;
            wr_ff    <= cyc.wr;
            cnt_ff   <= strobe_n;
            ce_n_ff  <= 1'b0;
            addr_ff  <= pin_addr;
            dout_ff  <= pin_dout;
            doe_n_ff <= pin_doe;
          end
        end
        fcm_pkg::E_SETUP: begin
          // Address is stable a cycle before the strobe falls, where the device latches it.
          st_ff   <= fcm_pkg::E_STROBE;
          we_n_ff <= ~wr_ff;
          oe_n_ff <= wr_ff;
        end
        fcm_pkg::E_STROBE: begin
          if (cnt_ff == 3'h0) begin
            st_ff    <= fcm_pkg::E_HOLD;
            we_n_ff  <= 1'b1;
            oe_n_ff  <= 1'b1;
            rdata_ff <= wr_ff ? rdata_ff : dq_in;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        fcm_pkg::E_HOLD: begin
          // Data stays driven past the rising strobe edge, where the device takes it.
          st_ff    <= fcm_pkg::E_IDLE;
          ce_n_ff  <= 1'b1;
          doe_n_ff <= 16'hFFFF;
        end
        default: st_ff <= fcm_pkg::E_IDLE;
      endcase
    end
  end

  assign cyc.done  = (st_ff == fcm_pkg::E_HOLD);
  assign cyc.rdata = rdata_ff;
  assign ce_n      = ce_n_ff;
  assign oe_n      = oe_n_ff;
  assign we_n      = we_n_ff;
  assign addr_pins = addr_ff;
  assign dq_out    = dout_ff;
  assign dq_oe_n   = doe_n_ff;
endmodule : fcm_bus_cycle
`default_nettype wire

// *** fcm_host.sv ***
// Flash command master: turns user operations into flash command write sequences and status polls.
//
// Behaviour
// - Unlock addresses are 555H/2AAH in word mode and AAAH/555H in byte mode.
// - Program is AAH, 55H, A0H unlock writes, then data to the target location.
// - Erase is AAH,55H,80H,AAH,55H then 10H for chip or 30H to a sector.
// - Silicon-ID is AAH,55H,90H; reads at offset 0 and 1 give maker and device codes.
// - Protect unlock is AAH,55H,80H,AAH,55H,20H to the first unlock address.
// - Each extra sector load must start within 30 us of the previous strobe rise.
`timescale 1ns/1ps
`default_nettype none
`include "fcm_consts.svh"
module fcm_host (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             byte_mode,
  input  wire logic             req_valid,
  output logic                  req_ready,
  input  wire fcm_pkg::fcm_op_t req_op,
  input  wire logic [17:0]      req_addr,
  input  wire logic [15:0]      req_data,
  output logic                  resp_valid,
  output logic [15:0]           resp_data,
  output logic                  resp_fail,
  output logic                  erase_active,
  output logic                  erase_suspended,
  output logic                  flash_reset_n,
  output logic                  flash_byte_n,
  output logic                  flash_ce_n,
  output logic                  flash_oe_n,
  output logic                  flash_we_n,
  output logic [16:0]           flash_addr,
  output logic [15:0]           flash_dq_out,
  output logic [15:0]           flash_dq_oe_n,
  input  wire logic [15:0]      flash_dq_in
);
  logic                rst_s1_ff;
  logic                rst_s2_ff;
  fcm_pkg::fcm_state_t state_ff;
  fcm_pkg::fcm_kind_t  kind_ff;
  fcm_pkg::fcm_op_t    op_ff;
  logic [17:0]         addr_ff;
  logic [15:0]         data_ff;
  logic [2:0]          step_ff;
  logic [10:0]         cnt_ff;
  logic [15:0]         first_ff;
  logic                erasing_ff;
  logic                suspended_ff;
  logic                fail_ff;
  logic                resp_valid_ff;
  logic [15:0]         resp_data_ff;
  logic                resp_fail_ff;
  logic                byte_n_ff;

  fcm_cyc_if cyc ();

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;

  fcm_bus_cycle u_engine (
    .clk       (clk),
    .rst_n     (rst_n),
    .byte_mode (byte_mode),
    .cyc       (cyc.eng),
    .ce_n      (flash_ce_n),
    .oe_n      (flash_oe_n),
    .we_n      (flash_we_n),
    .addr_pins (flash_addr),
    .dq_out    (flash_dq_out),
    .dq_oe_n   (flash_dq_oe_n),
    .dq_in     (flash_dq_in)
  );

  // First command byte after the two unlock writes, and the final byte of six-write or single-write commands.
  function automatic logic [15:0] cmd_first(input fcm_pkg::fcm_op_t op);
    case (op)
      fcm_pkg::OP_PROGRAM:        cmd_first = `FCM_D_PROGRAM;
      fcm_pkg::OP_READ_ID,
      fcm_pkg::OP_PROTECT_VERIFY: cmd_first = `FCM_D_SILICON_ID;
      default:                    cmd_first = `FCM_D_SETUP_ERASE;
    endcase
  endfunction : cmd_first

  function automatic logic [15:0] cmd_last(input fcm_pkg::fcm_op_t op);
    case (op)
      fcm_pkg::OP_CHIP_ERASE:     cmd_last = `FCM_D_CHIP_ERASE;
      fcm_pkg::OP_PROTECT_UNLOCK: cmd_last = `FCM_D_PROTECT_UNLOCK;
      fcm_pkg::OP_SUSPEND:        cmd_last = `FCM_D_SUSPEND;
      fcm_pkg::OP_RESET:          cmd_last = `FCM_D_RESET;
      default:                    cmd_last = `FCM_D_SECTOR_ERASE;
    endcase
  endfunction : cmd_last

  wire [17:0] unlock1   = byte_mode ? `FCM_U1_BYTE : `FCM_U1_WORD;
  wire [17:0] unlock2   = byte_mode ? `FCM_U2_BYTE : `FCM_U2_WORD;
  wire        is_prog   = (op_ff == fcm_pkg::OP_PROGRAM);
  wire        to_sector = (op_ff == fcm_pkg::OP_SECTOR_ERASE) || (op_ff == fcm_pkg::OP_ADD_SECTOR);
  wire        is_ident  = (op_ff == fcm_pkg::OP_READ_ID) || (op_ff == fcm_pkg::OP_PROTECT_VERIFY);
  wire [2:0]  last_step = is_prog ? 3'h3 : (is_ident ? 3'h2 : 3'h5);
  wire        step_u2   = (step_ff == 3'h1) || (step_ff == 3'h4);

  wire [17:0] wr_addr = (step_ff == 3'h3 && is_prog) ? addr_ff :
                        (step_ff == 3'h5 && to_sector) ? addr_ff :
                        step_u2 ? unlock2 : unlock1;
  wire [15:0] wr_data = (step_ff == 3'h3 && is_prog) ? data_ff :
                        (step_ff == 3'h5) ? cmd_last(op_ff) :
                        (step_ff == 3'h2) ? cmd_first(op_ff) :
                        step_u2 ? `FCM_D_UNLOCK2 : `FCM_D_UNLOCK1;
  wire [17:0] pv_ofs  = byte_mode ? `FCM_PV_OFS_BYTE : `FCM_PV_OFS_WORD;
  wire [17:0] rd_addr = (op_ff == fcm_pkg::OP_PROTECT_VERIFY) ? (addr_ff | pv_ofs) : addr_ff;

  assign cyc.start = (state_ff == fcm_pkg::S_ISSUE);
  assign cyc.wr    = (kind_ff == fcm_pkg::K_WRITE);
  assign cyc.addr  = cyc.wr ? wr_addr : rd_addr;
  assign cyc.wdata = wr_data;

  // Acceptance gate: which operations may be written to the device in its present mode.
  wire win_open  = (cnt_ff != 11'h000);
  wire ok_susp   = (req_op == fcm_pkg::OP_READ) || (req_op == fcm_pkg::OP_RESUME) ||
                   (req_op == fcm_pkg::OP_PROGRAM) || (req_op == fcm_pkg::OP_POLL);
  wire ok_erase  = (req_op == fcm_pkg::OP_SUSPEND) || (req_op == fcm_pkg::OP_POLL) ||
                   (req_op == fcm_pkg::OP_ADD_SECTOR && win_open);
  wire ok_ready  = (req_op != fcm_pkg::OP_SUSPEND) && (req_op != fcm_pkg::OP_RESUME) &&
                   (req_op != fcm_pkg::OP_ADD_SECTOR);
  wire op_ok     = suspended_ff ? ok_susp : (erasing_ff ? ok_erase : ok_ready);
  assign req_ready = (state_ff == fcm_pkg::S_IDLE) && op_ok;
  wire take      = req_valid && req_ready;
  wire single    = (req_op == fcm_pkg::OP_RESET) || (req_op == fcm_pkg::OP_SUSPEND) ||
                   (req_op == fcm_pkg::OP_RESUME) || (req_op == fcm_pkg::OP_ADD_SECTOR);
  wire rd_first  = (req_op == fcm_pkg::OP_READ);
  wire pol_first = (req_op == fcm_pkg::OP_POLL);

  // Poll evaluation over two consecutive reads.
  wire [15:0] second  = cyc.rdata;
  wire        still   = (first_ff[`FCM_BIT_TOGGLE] == second[`FCM_BIT_TOGGLE]);
  wire        settled = still && second[`FCM_BIT_POLL];
  wire        limit   = second[`FCM_BIT_LIMIT] && !still;
  wire        blocking = is_prog || (op_ff == fcm_pkg::OP_CHIP_ERASE) || (op_ff == fcm_pkg::OP_SUSPEND);
  // Suspend only needs the toggling to stop; data polling then shows array data.
  wire        done_ok = (op_ff == fcm_pkg::OP_SUSPEND) ? still : settled;
  wire        wr_end  = (kind_ff == fcm_pkg::K_WRITE) && (step_ff == last_step);
  wire        to_poll = is_prog || (op_ff == fcm_pkg::OP_CHIP_ERASE) || (op_ff == fcm_pkg::OP_SUSPEND);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= fcm_pkg::S_HWRST;
      kind_ff       <= fcm_pkg::K_WRITE;
      op_ff         <= fcm_pkg::OP_READ;
      addr_ff       <= 18'h0_0000;
      data_ff       <= 16'h0000;
      step_ff       <= 3'h0;
      cnt_ff        <= 11'(`FCM_RP_CYC);
      first_ff      <= 16'h0000;
      erasing_ff    <= 1'b0;
      suspended_ff  <= 1'b0;
      fail_ff       <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_data_ff  <= 16'h0000;
      resp_fail_ff  <= 1'b0;
      byte_n_ff     <= 1'b1;
    end else begin
      resp_valid_ff <= 1'b0;
      byte_n_ff     <= ~byte_mode;
      if (state_ff != fcm_pkg::S_HWRST && win_open) begin
        cnt_ff <= cnt_ff - 11'h001;
      end
      case (state_ff)
        fcm_pkg::S_HWRST: begin
          if (cnt_ff == 11'h000) begin
            state_ff <= fcm_pkg::S_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 11'h001;
          end
        end
        fcm_pkg::S_IDLE: begin
          if (take) begin
            state_ff <= fcm_pkg::S_ISSUE;
            op_ff    <= req_op;
            addr_ff  <= req_addr;
            data_ff  <= req_data;
            fail_ff  <= 1'b0;
            step_ff  <= single ? 3'h5 : 3'h0;
            kind_ff  <= rd_first ? fcm_pkg::K_READ : (pol_first ? fcm_pkg::K_POLLA : fcm_pkg::K_WRITE);
            if (req_op == fcm_pkg::OP_SUSPEND) begin
              cnt_ff <= 11'h000; // Suspend closes a still-open load window.
            end
          end
        end
        fcm_pkg::S_ISSUE: state_ff <= fcm_pkg::S_WAIT;
        fcm_pkg::S_WAIT: begin
          if (cyc.done) begin
            state_ff <= fcm_pkg::S_ISSUE;
            case (kind_ff)
              fcm_pkg::K_WRITE: begin
                if (!wr_end) begin
                  step_ff <= step_ff + 3'h1;
                end else if (fail_ff || op_ff == fcm_pkg::OP_RESET) begin
                  state_ff      <= fcm_pkg::S_IDLE;
                  erasing_ff    <= 1'b0;
                  suspended_ff  <= 1'b0;
                  resp_valid_ff <= 1'b1;
                  resp_fail_ff  <= fail_ff;
                end else if (is_ident) begin
                  kind_ff <= fcm_pkg::K_READ;
                end else if (to_poll) begin
                  kind_ff <= fcm_pkg::K_POLLA;
                end else begin
                  state_ff      <= fcm_pkg::S_IDLE;
                  resp_valid_ff <= 1'b1;
                  resp_fail_ff  <= 1'b0;
                  if (to_sector) begin
                    erasing_ff <= 1'b1;
                    cnt_ff     <= 11'(`FCM_LOADWIN_CYC);
                  end
                  if (op_ff == fcm_pkg::OP_RESUME) begin
                    suspended_ff <= 1'b0;
                    erasing_ff   <= 1'b1;
                  end
                end
              end
              fcm_pkg::K_READ: begin
                state_ff      <= fcm_pkg::S_IDLE;
                resp_valid_ff <= 1'b1;
                resp_data_ff  <= cyc.rdata;
                resp_fail_ff  <= 1'b0;
              end
              fcm_pkg::K_POLLA: begin
                first_ff <= cyc.rdata;
                kind_ff  <= fcm_pkg::K_POLLB;
              end
              default: begin
                if (done_ok) begin
                  state_ff      <= fcm_pkg::S_IDLE;
                  resp_valid_ff <= 1'b1;
                  resp_data_ff  <= second;
                  resp_fail_ff  <= 1'b0;
                  if (op_ff == fcm_pkg::OP_SUSPEND) begin
                    suspended_ff <= 1'b1;
                  end else if (op_ff == fcm_pkg::OP_POLL && !suspended_ff) begin
                    erasing_ff <= 1'b0;
                  end
                end else if (limit) begin
                  fail_ff <= 1'b1;
                  op_ff   <= fcm_pkg::OP_RESET;
                  step_ff <= 3'h5;
                  kind_ff <= fcm_pkg::K_WRITE;
                end else if (blocking) begin
                  kind_ff <= fcm_pkg::K_POLLA;
                end else begin
                  state_ff      <= fcm_pkg::S_IDLE;
                  resp_valid_ff <= 1'b1;
                  resp_data_ff  <= second;
                  resp_fail_ff  <= 1'b0;
                end
              end
            endcase
          end
        end
        default: state_ff <= fcm_pkg::S_IDLE;
      endcase
    end
  end

  assign flash_reset_n   = (state_ff != fcm_pkg::S_HWRST);
  assign flash_byte_n    = byte_n_ff;
  assign resp_valid      = resp_valid_ff;
  assign resp_data       = resp_data_ff;
  assign resp_fail       = resp_fail_ff;
  assign erase_active    = erasing_ff;
  assign erase_suspended = suspended_ff;
endmodule : fcm_host
`default_nettype wire

// *** fcm_host_checker.sv ***
// Assertions on the command master's pins.
`timescale 1ns/1ps
`default_nettype none
module fcm_host_checker (
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             req_ready,
  input wire fcm_pkg::fcm_op_t req_op,
  input wire logic             resp_valid,
  input wire logic             erase_active,
  input wire logic             erase_suspended,
  input wire logic             flash_reset_n,
  input wire logic             flash_ce_n,
  input wire logic             flash_oe_n,
  input wire logic             flash_we_n,
  input wire logic [16:0]      flash_addr,
  input wire logic [15:0]      flash_dq_out,
  input wire logic [15:0]      flash_dq_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  strobe_sel_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe_n == 16'h0000)
    else $error("bad write strobe");
  addr_setup_a: assert property ($fell(flash_we_n) |-> $stable(flash_addr))
    else $error("address moved at strobe fall");
  data_rise_a: assert property ($rose(flash_we_n) |-> $stable(flash_dq_out) && $stable(flash_addr))
    else $error("data moved at strobe rise");
  wr_width_a: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
    else $error("write strobe width wrong");
  rd_width_a: assert property ($fell(flash_oe_n) |=> !flash_oe_n [*2] ##1 flash_oe_n)
    else $error("read strobe width wrong");
  no_fight_a: assert property (!flash_oe_n |-> !flash_ce_n && flash_dq_oe_n[14:0] == 15'h7FFF)
    else $error("host drives data during read");
  resp_pulse_a: assert property (resp_valid |=> !resp_valid)
    else $error("response too long");
  susp_hold_a: assert property (erase_suspended |-> erase_active)
    else $error("suspended without erase");
  busy_refuse_a: assert property (erase_active && !erase_suspended && req_op != fcm_pkg::OP_SUSPEND &&
    req_op != fcm_pkg::OP_POLL && req_op != fcm_pkg::OP_ADD_SECTOR |-> !req_ready)
    else $error("request accepted during erase");
  resume_refuse_a: assert property (!erase_active && (req_op == fcm_pkg::OP_SUSPEND ||
    req_op == fcm_pkg::OP_RESUME) |-> !req_ready)
    else $error("suspend or resume without erase");
  hw_reset_a: assert property (!flash_reset_n |-> flash_ce_n && flash_we_n && flash_oe_n)
    else $error("strobe during hardware reset");
endmodule : fcm_host_checker

bind fcm_host fcm_host_checker u_chk (.clk(clk), .reset_n(reset_n), .req_ready(req_ready), .req_op(req_op),
  .resp_valid(resp_valid), .erase_active(erase_active), .erase_suspended(erase_suspended),
  .flash_reset_n(flash_reset_n), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n));
`default_nettype wire

// *** fcm_flash_model.sv ***
// Flash device model.
`timescale 1ns/1ps
`default_nettype none
module fcm_flash_model #(
  parameter logic [15:0] MAKER_CODE  = 16'h003C, // Arbitrary.
  parameter logic [15:0] DEVICE_CODE = 16'h1A2B, // Arbitrary.
  parameter int          BUSY_READS  = 3,
  parameter logic        PROTECTED   = 1'b1
) (
  input  wire logic        rst_n,
  input  wire logic        byte_n,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [16:0] addr,
  input  wire logic [15:0] dq_out,
  output logic [15:0]      dq_in
);
  int          n_wr, bad_wr, step, nxt, pbusy, ebusy;
  logic        susp, idm, unl, chip, tog;
  logic [17:0] wa, last_a;
  logic [15:0] last_d, held;
  wire logic [17:0] fa = byte_n ? {1'b0, addr} : {addr, dq_out[15]};
  wire logic [10:0] u1 = byte_n ? 11'h555 : 11'hAAA;
  wire logic [10:0] u2 = byte_n ? 11'h2AA : 11'h555;
  wire logic        busy = pbusy != 0 || (ebusy != 0 && !susp);
  wire logic [15:0] rdv = busy ? {8'h00, 1'b0, tog, 6'h00} :
    idm ? (fa[1] ? {15'h0000, PROTECTED} : fa[0] ? DEVICE_CODE : MAKER_CODE) : {fa[7:0], 8'hC3};
  // A released bus shows the inverse of the last value so a stale read cannot pass.
  assign dq_in = (!ce_n && !oe_n) ? rdv : ~held;

  always @(negedge we_n) wa = fa;

  always @(posedge we_n or negedge rst_n) begin
    if (!rst_n) begin
      {step, pbusy, ebusy, n_wr, bad_wr} = '0;
      {susp, idm, unl, chip, tog} = '0;
      held = 16'h0000;
    end else if (!ce_n) begin
      n_wr++;
      last_a = wa;
      last_d = dq_out;
      if (pbusy != 0) bad_wr++;
      else if (ebusy != 0 && !susp) begin
        if (dq_out[7:0] == 8'hB0) susp = 1'b1;
        else bad_wr++;
      end else if (susp && dq_out[7:0] == 8'h30) susp = 1'b0;
      else if (dq_out[7:0] == 8'hF0) begin
        step = 0;
        idm = 1'b0;
      end else begin
        nxt = 0;
        idm = 1'b0;
        case (step)
          0: if (wa[10:0] == u1 && dq_out[7:0] == 8'hAA) nxt = 1;
          1: if (wa[10:0] == u2 && dq_out[7:0] == 8'h55) nxt = 2;
          2: if (wa[10:0] == u1 && dq_out[7:0] == 8'hA0) nxt = 3;
            else if (wa[10:0] == u1 && dq_out[7:0] == 8'h80) nxt = 4;
            else if (wa[10:0] == u1 && dq_out[7:0] == 8'h90) idm = 1'b1;
          3: pbusy = BUSY_READS;
          4: if (wa[10:0] == u1 && dq_out[7:0] == 8'hAA) nxt = 5;
          5: if (wa[10:0] == u2 && dq_out[7:0] == 8'h55) nxt = 6;
          default: begin
            chip = wa[10:0] == u1 && dq_out[7:0] == 8'h10;
            unl = wa[10:0] == u1 && dq_out[7:0] == 8'h20;
            if (chip || dq_out[7:0] == 8'h30) ebusy = BUSY_READS;
          end
        endcase
        step = nxt;
      end
    end
  end

  always @(posedge oe_n) if (rst_n) begin
    held = rdv;
    if (busy) tog = ~tog;
    if (pbusy != 0) pbusy--;
    else if (ebusy != 0 && !susp) ebusy--;
  end
endmodule : fcm_flash_model
`default_nettype wire

// *** flash_command_state_machine_bench.sv ***
// Self-checking bench for the command master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR at %0t got %h expected %h", $time, (g), (e)); end end
module flash_command_state_machine_bench;
  localparam logic [15:0] MAKER = 16'h003C; // Arbitrary value.
  localparam logic [15:0] DEV   = 16'h1A2B; // Arbitrary value.
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              byte_mode = 1'b0;
  logic              req_valid = 1'b0;
  fcm_pkg::fcm_op_t  req_op = fcm_pkg::OP_READ;
  logic [17:0]       req_addr = 18'h0_0000;
  logic [15:0]       req_data = 16'h0000;
  wire logic         req_ready, resp_valid, resp_fail, erase_active, erase_suspended;
  wire logic         flash_reset_n, flash_byte_n, flash_ce_n, flash_oe_n, flash_we_n;
  wire logic [15:0]  resp_data, flash_dq_out, flash_dq_oe_n, flash_dq_in;
  wire logic [16:0]  flash_addr;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                w;
  logic [15:0]       got;
  logic              got_fail;

  always #12.5 clk = ~clk;

  fcm_host u_dut (.clk(clk), .reset_n(reset_n), .byte_mode(byte_mode), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_fail(resp_fail), .erase_active(erase_active), .erase_suspended(erase_suspended),
    .flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in));

  fcm_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEV)) u_flash (.rst_n(flash_reset_n), .byte_n(flash_byte_n),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr), .dq_out(flash_dq_out),
    .dq_in(flash_dq_in));

  task automatic do_op(input fcm_pkg::fcm_op_t op, input logic [17:0] a, input logic [15:0] d);
    int k;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    k = 0;
    do begin @(negedge clk); k++; end while (req_ready !== 1'b1 && k < 200);
    `CHK(req_ready, 1'b1)
    @(posedge clk);
    req_valid <= 1'b0;
    k = 0;
    do begin @(negedge clk); k++; end while (resp_valid !== 1'b1 && k < 4000);
    `CHK(resp_valid, 1'b1)
    got = resp_data;
    got_fail = resp_fail;
    @(posedge clk);
  endtask : do_op

  task automatic t_program();
    w = u_flash.n_wr;
    do_op(fcm_pkg::OP_PROGRAM, 18'h0_1234, 16'hBEEF);
    `CHK(u_flash.n_wr - w, 4)
    `CHK(u_flash.last_a, 18'h0_1234)
    `CHK(u_flash.last_d, 16'hBEEF)
    `CHK(u_flash.bad_wr, 0)
    `CHK(u_flash.pbusy, 0)
    `CHK(got_fail, 1'b0)
    $display("test program done");
  endtask : t_program

  task automatic t_ident();
    do_op(fcm_pkg::OP_READ_ID, 18'h0_0000, 16'h0000);
    `CHK(got, MAKER)
    do_op(fcm_pkg::OP_READ_ID, 18'h0_0001, 16'h0000);
    `CHK(got, DEV)
    do_op(fcm_pkg::OP_PROTECT_VERIFY, 18'h0_8000, 16'h0000);
    `CHK(got, 16'h0001)
    do_op(fcm_pkg::OP_RESET, 18'h0_0000, 16'h0000);
    `CHK(u_flash.last_d[7:0], 8'hF0)
    do_op(fcm_pkg::OP_READ, 18'h0_0021, 16'h0000);
    `CHK(got, 16'h21C3)
    $display("test ident done");
  endtask : t_ident

  task automatic t_erase();
    int k;
    do_op(fcm_pkg::OP_SECTOR_ERASE, 18'h1_0000, 16'h0000);
    `CHK(erase_active, 1'b1)
    `CHK(u_flash.last_a, 18'h1_0000)
    `CHK(u_flash.last_d, 16'h0030)
    req_op <= fcm_pkg::OP_RESET;
    @(posedge clk);
    `CHK(req_ready, 1'b0)
    do_op(fcm_pkg::OP_SUSPEND, 18'h0_0000, 16'h0000);
    `CHK(u_flash.susp, 1'b1)
    `CHK(erase_suspended, 1'b1)
    do_op(fcm_pkg::OP_READ, 18'h0_0040, 16'h0000);
    `CHK(got, 16'h40C3)
    do_op(fcm_pkg::OP_RESUME, 18'h0_0000, 16'h0000);
    `CHK(u_flash.susp, 1'b0)
    `CHK(erase_suspended, 1'b0)
    k = 0;
    while (erase_active === 1'b1 && k < 20) begin do_op(fcm_pkg::OP_POLL, 18'h1_0000, 16'h0000); k++; end
    `CHK(erase_active, 1'b0)
    `CHK(u_flash.bad_wr, 0)
    $display("test erase done");
  endtask : t_erase

  task automatic t_byte();
    byte_mode <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(flash_byte_n, 1'b0)
    w = u_flash.n_wr;
    do_op(fcm_pkg::OP_CHIP_ERASE, 18'h0_0000, 16'h0000);
    `CHK(u_flash.n_wr - w, 6)
    `CHK(u_flash.chip, 1'b1)
    `CHK(u_flash.last_a[10:0], 11'hAAA)
    `CHK(u_flash.ebusy, 0)
    do_op(fcm_pkg::OP_PROTECT_UNLOCK, 18'h0_0000, 16'h0000);
    `CHK(u_flash.unl, 1'b1)
    byte_mode <= 1'b0;
    $display("test byte done");
  endtask : t_byte

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (4) @(posedge clk);
    `CHK(flash_reset_n, 1'b0)
    `CHK(flash_ce_n, 1'b1)
    reset_n <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK(flash_reset_n, 1'b1)
    t_program();
    t_ident();
    t_erase();
    t_byte();
    close_out();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule : flash_command_state_machine_bench
`default_nettype wire
